// ---- ood_pkg.sv ----
// Constants and types shared by the operand field decoder.
// Assumes one core clock and a plain byte-wide register port.
package ood_pkg;

    // Instruction class supplied by fetch alongside each word.
    typedef enum logic [3:0] {
        KIND_BYTE, KIND_BIT, KIND_LIT8, KIND_PTR_LIT, KIND_MOVFF, KIND_IDX_MOVE,
        KIND_REL8, KIND_REL11, KIND_GOTO, KIND_CALL, KIND_RETURN, KIND_TABLE,
        KIND_OTHER
    } ood_kind_t;

    // Program read pointer update kinds, in field order.
    typedef enum logic [1:0] {
        PTR_KEEP, PTR_POST_INC, PTR_POST_DEC, PTR_PRE_INC
    } ood_ptr_mode_t;

    localparam int PTR_W = 21;
    localparam int BANK_W = 4;
    localparam int ADDR_W = 12;
    localparam int LIT_W = 20;
    localparam int FLAG_W = 5;
    localparam int OFS_W = 7;

    // Register port offsets.
    localparam logic [7:0] REG_BANK = 8'h00;
    localparam logic [7:0] REG_PTR_LO = 8'h01;
    localparam logic [7:0] REG_PTR_HI = 8'h02;
    localparam logic [7:0] REG_PTR_UP = 8'h03;
    localparam logic [7:0] REG_FLAGS = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h05;

    // Instruction word field positions.
    localparam int FILE_LSB = 0;
    localparam int ACCESS_POS = 8;
    localparam int DEST_POS = 9;
    localparam int BITPOS_LSB = 9;
    localparam int PTRSEL_LSB = 4;
    localparam int RET_FAST_POS = 0;
    localparam int CALL_FAST_POS = 8;
    localparam int MODE_LSB = 0;
    localparam int TAG_LSB = 12;
    localparam logic [3:0] SECOND_TAG = 4'hF;

    // Flag bit positions: carry, digit carry, zero, overflow, negative.
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;

    // Values after reset and fixed codes.
    localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
    localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
    localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;

    // One instruction cycle spans four core clock periods.
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_LAST = 2'(PHASES_PER_CYCLE - 1);

endpackage

// ---- ood_decoder.sv ----
// Operand field decoder for an 8-bit core: splits instruction words into fields,
// keeps the program read pointer, bank select and ALU flags.
// Assumes fetch presents each word with its class on the core clock.
// Operation
// - Bank-access bit 0 selects access RAM and ignores bank select.
// - Bank-access bit 1 forms the address from the bank select value.
// - Bit field gives bit index 0 to 7 of an 8-bit register.
// - Target bit 0 sends the result to the accumulator only.
// - Target bit 1 writes the result back to the file register.
// - Location field is an 8-bit address or a 2-bit pointer choice.
// - Two-word move reads a full 12-bit source address, bank free.
// - Two-word move writes to a separate full 12-bit destination.
// - Literals of 8, 12 or 20 bits are extracted as immediates.
// - Table access in keep mode leaves the read pointer unchanged.
// - Table access supports post-increment, post-decrement and pre-increment.
// - Relative branches add a signed displacement to the program counter.
// - Call and go-to take the target field as an absolute address.
// - Quick-return bit 0 neither saves nor restores shadow copies.
// - Quick-return bit 1 saves on call and restores on return.
// - A 21-bit program read pointer addresses table accesses.
// - Seven-bit source and destination offsets feed indexed addressing.
// - Five ALU flags are held and updated by the ALU.
// - Don't-care instruction bits never affect decoding.
// - A lone second word with four ones on top decodes as no-operation.
// - Instruction cycle is four clocks; skips and jumps add a no-operation.
`timescale 1ns/1ps

module ood_decoder
    import ood_pkg::*;
(
    input logic i_ref_clk, // Core clock.
    input logic i_reset_n, // Asynchronous reset, active low.
    input logic i_clk_en, // Freezes all state but the reset synchronizer while low.
    input logic i_instr_valid, // Word on i_instr is present.
    input logic [15:0] i_instr, // Instruction word.
    input ood_kind_t i_kind, // Class of a first word.
    input logic i_skip, // Skip true or program counter changed.
    input logic [PTR_W-1:0] i_pc, // Program counter of the word.
    input logic i_flags_we, // ALU flag update strobe.
    input logic [FLAG_W-1:0] i_flags, // New ALU flags.
    input logic [7:0] i_addr, // Register address.
    input logic [7:0] i_wdata, // Register write data.
    input logic i_wr, // Register write strobe.
    input logic i_rd, // Register read strobe.
    output logic [7:0] o_rdata, // Read data, cycle after i_rd.
    output logic o_instr_ready, // Word is taken this cycle.
    output logic o_dec_valid, // Decoded instruction pulse.
    output logic o_dec_nop, // Decoded as no-operation.
    output ood_kind_t o_kind, // Class of the decoded instruction.
    output logic [ADDR_W-1:0] o_file_addr, // Banked file address.
    output logic [2:0] o_bit_pos, // Bit index.
    output logic [7:0] o_bit_mask, // One-hot bit mask.
    output logic o_to_accum, // Result goes to accumulator.
    output logic o_to_file, // Result goes to file register.
    output logic [1:0] o_ptr_sel, // Pointer register choice.
    output logic o_move_valid, // Two-word move decoded.
    output logic [ADDR_W-1:0] o_src_addr, // Move source.
    output logic [ADDR_W-1:0] o_dst_addr, // Move destination.
    output logic [OFS_W-1:0] o_src_offset, // Indexed source offset.
    output logic [OFS_W-1:0] o_dst_offset, // Indexed destination offset.
    output logic o_lit_valid, // Literal decoded.
    output logic [LIT_W-1:0] o_literal, // Zero-extended literal.
    output logic o_jump_valid, // Jump target decoded.
    output logic [PTR_W-1:0] o_target, // Jump target.
    output logic o_shadow_save, // Save shadow copies.
    output logic o_shadow_restore, // Restore shadow copies.
    output logic o_table_valid, // Table access decoded.
    output logic [PTR_W-1:0] o_table_addr, // Program memory address.
    output logic [FLAG_W-1:0] o_flags // ALU flags.
);

    function automatic logic two_word(input ood_kind_t k);
        two_word = k inside {KIND_PTR_LIT, KIND_MOVFF, KIND_IDX_MOVE, KIND_GOTO, KIND_CALL};
    endfunction

    logic rst_meta_reg, rst_n_reg;
    logic [1:0] phase_reg;
    logic pending_reg, skip_pend_reg;
    logic [15:0] word1_reg;
    ood_kind_t kind1_reg;
    logic [BANK_W-1:0] bank_reg;
    logic [PTR_W-1:0] ptr_reg, ptr_next;
    logic [FLAG_W-1:0] flags_reg;
    logic [7:0] rdata_reg;
    logic valid_reg, nop_reg, move_reg, lit_reg, jump_reg, table_reg, save_reg, restore_reg;
    ood_kind_t kind_reg;
    logic [ADDR_W-1:0] file_reg, src_reg, dst_reg;
    logic [2:0] bitpos_reg;
    logic [7:0] mask_reg;
    logic accum_reg, tofile_reg;
    logic [1:0] psel_reg;
    logic [OFS_W-1:0] sofs_reg, dofs_reg;
    logic [LIT_W-1:0] lit_val_reg;
    logic [PTR_W-1:0] target_reg, taddr_reg;

    // The reset is released through two flops so every register leaves it together.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // Word classification.
    wire take = i_clk_en && (phase_reg == PHASE_LAST) && i_instr_valid;
    wire tag_f = i_instr[TAG_LSB +: 4] == SECOND_TAG;
    wire squash = take && skip_pend_reg;
    wire second = take && !skip_pend_reg && pending_reg && tag_f;
    wire lone = take && !skip_pend_reg && !pending_reg && tag_f;
    wire first = take && !skip_pend_reg && !tag_f;
    wire first_two = first && two_word(i_kind);
    wire done = (first && !two_word(i_kind)) || second;
    wire nop_now = squash || lone;

    // Fields of the opening word come from the held copy on the second word.
    wire [15:0] w1 = second ? word1_reg : i_instr;
    wire [15:0] w2 = i_instr;
    ood_kind_t eff_kind;
    ood_ptr_mode_t mode;
    assign eff_kind = second ? kind1_reg : i_kind;
    assign mode = ood_ptr_mode_t'(w1[MODE_LSB +: 2]);

    // Only the documented bits of each field are looked at.
    wire [BANK_W-1:0] bank_used = w1[ACCESS_POS] ? bank_reg : ACCESS_BANK;
    wire [ADDR_W-1:0] file_next = {bank_used, w1[FILE_LSB +: 8]};
    wire [2:0] bitpos_next = w1[BITPOS_LSB +: 3];
    wire [7:0] mask_next = 8'h01 << bitpos_next;
    wire [LIT_W-1:0] lit_next =
        (eff_kind == KIND_LIT8) ? {12'h000, w1[7:0]} :
        (eff_kind == KIND_PTR_LIT) ? {8'h00, w1[3:0], w2[7:0]} :
        {w2[11:0], w1[7:0]};
    wire lit_kind = eff_kind inside {KIND_LIT8, KIND_PTR_LIT, KIND_GOTO, KIND_CALL};
    wire [PTR_W-1:0] rel8 = i_pc + {{13{w1[7]}}, w1[7:0]};
    wire [PTR_W-1:0] rel11 = i_pc + {{10{w1[10]}}, w1[10:0]};
    wire [PTR_W-1:0] target_next =
        (eff_kind == KIND_REL8) ? rel8 :
        (eff_kind == KIND_REL11) ? rel11 :
        {1'b0, lit_next};
    wire jump_kind = eff_kind inside {KIND_REL8, KIND_REL11, KIND_GOTO, KIND_CALL};
    wire save_next = (eff_kind == KIND_CALL) && w1[CALL_FAST_POS];
    wire restore_next = (eff_kind == KIND_RETURN) && w1[RET_FAST_POS];

    // Program read pointer stepping.
    wire table_take = done && (eff_kind == KIND_TABLE);
    wire [PTR_W-1:0] ptr_inc = ptr_reg + 21'h000001;
    wire [PTR_W-1:0] taddr_next = (mode == PTR_PRE_INC) ? ptr_inc : ptr_reg;
    always_comb begin
        unique case (mode)
            PTR_KEEP: ptr_next = ptr_reg;
            PTR_POST_INC: ptr_next = ptr_inc;
            PTR_POST_DEC: ptr_next = ptr_reg - 21'h000001;
            PTR_PRE_INC: ptr_next = ptr_inc;
        endcase
    end

    // Register port decode.
    wire wr_en = i_clk_en && i_wr;
    wire wr_bank = wr_en && (i_addr == REG_BANK);
    wire wr_lo = wr_en && (i_addr == REG_PTR_LO);
    wire wr_hi = wr_en && (i_addr == REG_PTR_HI);
    wire wr_up = wr_en && (i_addr == REG_PTR_UP);
    wire wr_flags = wr_en && (i_addr == REG_FLAGS);
    wire [7:0] rd_mux =
        (i_addr == REG_BANK) ? {4'h0, bank_reg} :
        (i_addr == REG_PTR_LO) ? ptr_reg[7:0] :
        (i_addr == REG_PTR_HI) ? ptr_reg[15:8] :
        (i_addr == REG_PTR_UP) ? {3'h0, ptr_reg[20:16]} :
        (i_addr == REG_FLAGS) ? {3'h0, flags_reg} :
        (i_addr == REG_STATE) ? {4'h0, skip_pend_reg, pending_reg, phase_reg} :
        8'h00;

    // A table step owns the pointer in that cycle, so a software write then is dropped.
    always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ptr_reg <= PTR_RST;
        end else if (table_take) begin
            ptr_reg <= ptr_next;
        end else if (wr_lo) begin
            ptr_reg[7:0] <= i_wdata;
        end else if (wr_hi) begin
            ptr_reg[15:8] <= i_wdata;
        end else if (wr_up) begin
            ptr_reg[20:16] <= i_wdata[4:0];
        end
    end

    // ALU updates win over a software write in the same cycle.
    always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            flags_reg <= FLAGS_RST;
            bank_reg <= BANK_RST;
            rdata_reg <= 8'h00;
        end else if (i_clk_en) begin
            if (i_flags_we) begin
                flags_reg <= i_flags;
            end else if (wr_flags) begin
                flags_reg <= i_wdata[FLAG_W-1:0];
            end
            if (wr_bank) begin
                bank_reg <= i_wdata[BANK_W-1:0];
            end
            rdata_reg <= i_rd ? rd_mux : 8'h00;
        end
    end

    // Sequencing: phase count, held first word, pending skip.
    always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            phase_reg <= 2'h0;
            pending_reg <= 1'b0;
            skip_pend_reg <= 1'b0;
            word1_reg <= 16'h0000;
            kind1_reg <= KIND_OTHER;
        end else if (i_clk_en) begin
            phase_reg <= phase_reg + 2'h1;
            skip_pend_reg <= i_skip || (skip_pend_reg && !take);
            if (take) begin
                pending_reg <= first_two;
            end
            if (first_two) begin
                word1_reg <= i_instr;
                kind1_reg <= i_kind;
            end
        end
    end

    // Decoded fields load at the end of the instruction cycle and hold until the next; the strobes pulse for one clock.
    always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            {valid_reg, nop_reg, move_reg, lit_reg, jump_reg} <= 5'h00;
            {table_reg, save_reg, restore_reg, accum_reg, tofile_reg} <= 5'h00;
            kind_reg <= KIND_OTHER;
            {file_reg, src_reg, dst_reg} <= 36'h000000000;
            {bitpos_reg, mask_reg, psel_reg} <= 13'h0000;
            {sofs_reg, dofs_reg} <= 14'h0000;
            lit_val_reg <= 20'h00000;
            {target_reg, taddr_reg} <= 42'h00000000000;
        end else if (i_clk_en) begin
            valid_reg <= done || nop_now;
            nop_reg <= nop_now;
            move_reg <= done && (eff_kind == KIND_MOVFF);
            lit_reg <= done && lit_kind;
            jump_reg <= done && jump_kind;
            table_reg <= table_take;
            save_reg <= done && save_next;
            restore_reg <= done && restore_next;
            if (done) begin
                kind_reg <= eff_kind;
                file_reg <= file_next;
                bitpos_reg <= bitpos_next;
                mask_reg <= mask_next;
                accum_reg <= !w1[DEST_POS];
                tofile_reg <= w1[DEST_POS];
                psel_reg <= w1[PTRSEL_LSB +: 2];
                src_reg <= w1[ADDR_W-1:0];
                dst_reg <= w2[ADDR_W-1:0];
                sofs_reg <= w1[OFS_W-1:0];
                dofs_reg <= w2[OFS_W-1:0];
                lit_val_reg <= lit_next;
                target_reg <= target_next;
                taddr_reg <= taddr_next;
            end else if (nop_now) begin
                kind_reg <= KIND_OTHER;
            end
        end
    end

    assign o_rdata = rdata_reg;
    assign o_instr_ready = take;
    assign o_dec_valid = valid_reg;
    assign o_dec_nop = nop_reg;
    assign o_kind = kind_reg;
    assign o_file_addr = file_reg;
    assign o_bit_pos = bitpos_reg;
    assign o_bit_mask = mask_reg;
    assign o_to_accum = accum_reg;
    assign o_to_file = tofile_reg;
    assign o_ptr_sel = psel_reg;
    assign o_move_valid = move_reg;
    assign o_src_addr = src_reg;
    assign o_dst_addr = dst_reg;
    assign o_src_offset = sofs_reg;
    assign o_dst_offset = dofs_reg;
    assign o_lit_valid = lit_reg;
    assign o_literal = lit_val_reg;
    assign o_jump_valid = jump_reg;
    assign o_target = target_reg;
    assign o_shadow_save = save_reg;
    assign o_shadow_restore = restore_reg;
    assign o_table_valid = table_reg;
    assign o_table_addr = taddr_reg;
    assign o_flags = flags_reg;

    // A stalled clock enable aborts every check in flight.
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n_reg || !i_clk_en);

    sequence s_move_open;
        first_two && (i_kind == KIND_MOVFF);
    endsequence
    sequence s_move_pair;
        s_move_open ##4 second;
    endsequence

    access_bank_a: assert property (done && !w1[ACCESS_POS] |=>
        o_file_addr == {ACCESS_BANK, $past(w1[7:0])})
        else $error("Access RAM address formed wrongly.");
    banked_addr_a: assert property (done && w1[ACCESS_POS] |=>
        o_file_addr == {$past(bank_reg), $past(w1[7:0])})
        else $error("Banked address formed wrongly.");
    bit_mask_a: assert property (o_dec_valid |->
        o_bit_mask == (8'h01 << o_bit_pos))
        else $error("Bit mask does not match bit index.");
    dest_select_a: assert property (done |=>
        o_to_file == $past(w1[DEST_POS]) && o_to_accum != o_to_file)
        else $error("Result destination wrong.");
    move_pair_a: assert property (s_move_pair |=>
        o_move_valid && o_src_addr == $past(word1_reg[11:0]) && o_dst_addr == $past(i_instr[11:0]))
        else $error("Two-word move addresses wrong.");
    ptr_keep_a: assert property (table_take && mode == PTR_KEEP |=>
        $stable(ptr_reg) && o_table_addr == ptr_reg)
        else $error("Pointer moved in keep mode.");
    ptr_pre_a: assert property (table_take && mode == PTR_PRE_INC |=>
        o_table_addr == $past(ptr_reg) + 21'h000001 && ptr_reg == o_table_addr)
        else $error("Pre-increment access wrong.");
    ptr_post_dec_a: assert property (table_take && mode == PTR_POST_DEC |=>
        o_table_addr == $past(ptr_reg) && ptr_reg == $past(ptr_reg) - 21'h000001)
        else $error("Post-decrement access wrong.");
    rel_branch_a: assert property (done && eff_kind == KIND_REL8 |=>
        o_jump_valid && o_target == $past(i_pc) + {{13{$past(i_instr[7])}}, $past(i_instr[7:0])})
        else $error("Relative target wrong.");
    fast_return_a: assert property (done && eff_kind == KIND_RETURN |=>
        o_shadow_restore == $past(i_instr[RET_FAST_POS]) && !o_shadow_save)
        else $error("Shadow restore wrong.");
    lone_nop_a: assert property (lone |=>
        o_dec_valid && o_dec_nop && !o_jump_valid && !o_move_valid)
        else $error("Lone second word not a no-operation.");
    flag_update_a: assert property (i_flags_we |=>
        o_flags == $past(i_flags))
        else $error("ALU flags not updated.");
    cycle_len_a: assert property (o_dec_valid |=> !o_dec_valid [*3])
        else $error("Instruction cycle shorter than four clocks.");

endmodule // ood_decoder

// ---- opcode_operand_field_decoder_tb.sv ----
// Self-checking bench for the operand field decoder.
// Assumes the decoder alone on one core clock, with its byte register port driven here.
`timescale 1ns/1ps

module opcode_operand_field_decoder_tb
    import ood_pkg::*;
;
    logic i_ref_clk, i_reset_n, i_clk_en, i_instr_valid, i_skip, i_flags_we, i_wr, i_rd;
    logic [15:0] i_instr;
    ood_kind_t i_kind, o_kind, k;
    logic [PTR_W-1:0] i_pc, o_target, o_table_addr, pc, ta, m_ptr;
    logic [FLAG_W-1:0] i_flags, o_flags;
    logic [7:0] i_addr, i_wdata, o_rdata, o_bit_mask;
    logic o_instr_ready, o_dec_valid, o_dec_nop, o_to_accum, o_to_file, o_move_valid;
    logic o_lit_valid, o_jump_valid, o_shadow_save, o_shadow_restore, o_table_valid;
    logic [ADDR_W-1:0] o_file_addr, o_src_addr, o_dst_addr, fa;
    logic [2:0] o_bit_pos;
    logic [1:0] o_ptr_sel, md;
    logic [OFS_W-1:0] o_src_offset, o_dst_offset;
    logic [LIT_W-1:0] o_literal;
    logic [15:0] w1, w2;
    logic [31:0] r1, r2;
    logic [3:0] m_bank;
    integer seed;
    int error_cnt, checks;
    ood_kind_t kinds[11] = '{KIND_BYTE, KIND_BIT, KIND_LIT8, KIND_PTR_LIT, KIND_MOVFF,
        KIND_IDX_MOVE, KIND_REL8, KIND_REL11, KIND_GOTO, KIND_CALL, KIND_RETURN};

    ood_decoder dut (.i_ref_clk, .i_reset_n, .i_clk_en, .i_instr_valid, .i_instr, .i_kind,
        .i_skip, .i_pc, .i_flags_we, .i_flags, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_instr_ready, .o_dec_valid, .o_dec_nop, .o_kind, .o_file_addr, .o_bit_pos,
        .o_bit_mask, .o_to_accum, .o_to_file, .o_ptr_sel, .o_move_valid, .o_src_addr,
        .o_dst_addr, .o_src_offset, .o_dst_offset, .o_lit_valid, .o_literal, .o_jump_valid,
        .o_target, .o_shadow_save, .o_shadow_restore, .o_table_valid, .o_table_addr, .o_flags);

    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk_fld(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD field at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD register at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Every bus task starts just after a rising edge; a write leaves one idle cycle behind it, a read two.
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(negedge i_ref_clk);
        chk_reg(o_rdata, exp);
        @(negedge i_ref_clk);
        chk_reg(o_rdata, 8'h00);
        @(posedge i_ref_clk);
    endtask

    task automatic ptr_chk();
        reg_rd(REG_PTR_LO, m_ptr[7:0]);
        reg_rd(REG_PTR_HI, m_ptr[15:8]);
        reg_rd(REG_PTR_UP, {3'h0, m_ptr[20:16]});
    endtask

    // Offers the word after a rising edge, watches ready mid-cycle so that the take edge is
    // known before it comes, then looks at the cycle after the take.
    task automatic issue(input logic [15:0] w, input ood_kind_t kd, input logic last);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_instr <= w;
        i_kind <= kd;
        i_instr_valid <= 1'b1;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (o_instr_ready !== 1'b1 && n < 8);
        if (o_instr_ready !== 1'b1) begin
            error_cnt++;
            close_out();
        end else begin
            @(posedge i_ref_clk);
            i_instr_valid <= 1'b0;
            @(negedge i_ref_clk);
            chk_fld(o_dec_valid, last);
        end
    endtask

    initial begin
        seed = 32'h7f3b;
        {i_reset_n, i_clk_en, i_instr_valid, i_skip, i_flags_we, i_wr, i_rd} = 7'h20;
        {i_instr, i_pc, i_flags, i_addr, i_wdata} = '0;
        i_kind = KIND_OTHER;
        error_cnt = 0;
        checks = 0;
        repeat (10) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        chk_fld(o_kind, KIND_OTHER);
        reg_rd(REG_BANK, {4'h0, BANK_RST});
        reg_rd(REG_FLAGS, {3'h0, FLAGS_RST});
        m_ptr = PTR_RST;
        ptr_chk();
        reg_wr(8'hA7, 8'h5A);
        reg_rd(8'hA7, 8'h00);
        // Random words fill the bits that the decoder must not look at.
        for (int i = 0; i < 33; i++) begin
            r1 = $random(seed);
            r2 = $random(seed);
            w1 = {1'b0, r1[14:0]};
            w2 = {4'hF, r2[11:0]};
            k = kinds[i % 11];
            pc = r2[31:11];
            m_bank = r1[31:28];
            reg_wr(REG_BANK, {4'h0, m_bank});
            i_pc <= pc;
            fa = w1[8] ? {m_bank, w1[7:0]} : {4'h0, w1[7:0]};
            if (k inside {KIND_PTR_LIT, KIND_MOVFF, KIND_IDX_MOVE, KIND_GOTO, KIND_CALL}) begin
                issue(w1, k, 1'b0);
                issue(w2, KIND_OTHER, 1'b1);
            end else begin
                issue(w1, k, 1'b1);
            end
            chk_fld({o_dec_nop, o_kind}, {1'b0, k});
            case (k)
                KIND_BYTE: begin
                    chk_fld(o_file_addr, fa);
                    chk_fld({o_to_file, o_to_accum}, {w1[9], !w1[9]});
                end
                KIND_BIT: begin
                    chk_fld(o_file_addr, fa);
                    chk_fld({o_bit_pos, o_bit_mask}, {w1[11:9], 8'h1 << w1[11:9]});
                end
                KIND_LIT8: chk_fld({o_lit_valid, o_literal}, {1'b1, 12'h0, w1[7:0]});
                KIND_PTR_LIT: chk_fld({o_ptr_sel, o_literal}, {w1[5:4], 8'h0, w1[3:0], w2[7:0]});
                KIND_MOVFF: chk_fld({o_move_valid, o_src_addr, o_dst_addr}, {1'b1, w1[11:0], w2[11:0]});
                KIND_IDX_MOVE: chk_fld({o_src_offset, o_dst_offset}, {w1[6:0], w2[6:0]});
                KIND_REL8: chk_fld({o_jump_valid, o_target}, {1'b1, pc + {{13{w1[7]}}, w1[7:0]}});
                KIND_REL11: chk_fld({o_jump_valid, o_target}, {1'b1, pc + {{10{w1[10]}}, w1[10:0]}});
                KIND_GOTO: chk_fld({o_jump_valid, o_target}, {1'b1, 1'b0, w2[11:0], w1[7:0]});
                KIND_CALL: begin
                    chk_fld({o_jump_valid, o_target}, {1'b1, 1'b0, w2[11:0], w1[7:0]});
                    chk_fld(o_shadow_save, w1[8]);
                end
                default: chk_fld({o_shadow_restore, o_shadow_save}, {w1[0], 1'b0});
            endcase
            @(posedge i_ref_clk);
        end
        // A lone second word, a skipped word, and a first word cut short by a new one.
        issue({4'hF, r1[11:0]}, KIND_BYTE, 1'b1);
        chk_fld({o_dec_nop, o_kind}, {1'b1, KIND_OTHER});
        @(posedge i_ref_clk);
        i_skip <= 1'b1;
        @(posedge i_ref_clk);
        i_skip <= 1'b0;
        issue(w1, KIND_BYTE, 1'b1);
        chk_fld({o_dec_nop, o_kind}, {1'b1, KIND_OTHER});
        @(posedge i_ref_clk);
        issue(w1, KIND_GOTO, 1'b0);
        issue(w1, KIND_BYTE, 1'b1);
        chk_fld({o_dec_nop, o_kind}, {1'b0, KIND_BYTE});
        @(posedge i_ref_clk);
        // The ALU update must win over a software write landing on the same edge.
        i_flags <= r2[4:0];
        i_flags_we <= 1'b1;
        i_addr <= REG_FLAGS;
        i_wdata <= {3'h0, ~r2[4:0]};
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_flags_we <= 1'b0;
        i_wr <= 1'b0;
        @(posedge i_ref_clk);
        chk_fld(o_flags, r2[4:0]);
        // With the clock enable low an ALU update must not land.
        i_clk_en <= 1'b0;
        i_flags <= ~r2[4:0];
        i_flags_we <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_flags_we <= 1'b0;
        i_clk_en <= 1'b1;
        @(posedge i_ref_clk);
        chk_fld(o_flags, r2[4:0]);
        reg_rd(REG_FLAGS, {3'h0, r2[4:0]});
        reg_wr(REG_FLAGS, 8'h15);
        reg_rd(REG_FLAGS, 8'h15);
        // Start near the top so that the post-increment wraps the pointer to zero.
        m_ptr = 21'h1FFFFE;
        reg_wr(REG_PTR_LO, 8'hFE);
        reg_wr(REG_PTR_HI, 8'hFF);
        reg_wr(REG_PTR_UP, 8'h1F);
        for (int j = 0; j < 6; j++) begin
            md = (j < 4) ? 2'(j) : 2'h1;
            ta = (md == 2'h3) ? m_ptr + 21'h1 : m_ptr;
            if (md == 2'h2) m_ptr = m_ptr - 21'h1;
            else if (md != 2'h0) m_ptr = m_ptr + 21'h1;
            r1 = $random(seed);
            issue({1'b0, r1[14:2], md}, KIND_TABLE, 1'b1);
            chk_fld({o_table_valid, o_table_addr}, {1'b1, ta});
            @(posedge i_ref_clk);
            ptr_chk();
        end
        close_out();
    end
endmodule // opcode_operand_field_decoder_tb
